// File: hw/rrw_consts.svh
// constants for the record window and syndrome block
`ifndef RRW_CONSTS_SVH
`define RRW_CONSTS_SVH

// system register encodings {op0,op1,crn,crm,op2}
`define RRW_ENC_W 16
`define RRW_ENC_FI_CTL 16'hC791
`define RRW_ENC_FI_FEAT 16'hC790
`define RRW_ENC_REC_STAT 16'hC2A2
`define RRW_ENC_SYN_OS 16'hC290
`define RRW_ENC_SYN_HYP 16'hE290

// syndrome field positions
`define RRW_CLASS_HI 31
`define RRW_CLASS_LO 26
`define RRW_LEN_BIT 25
`define RRW_SYN_HI 24
`define RRW_FMT_BIT 24
`define RRW_ERRTYPE_HI 12
`define RRW_ERRTYPE_LO 10
`define RRW_ABORT_TYPE_BIT 9
`define RRW_CLASS_ZERO 6'h00

// auxiliary control enable bit
`define RRW_AUX_EN_BIT 5

// reset values
`define RRW_SYN_RESET 32'h0000_0000
`define RRW_DATA_RESET 64'h0000_0000_0000_0000

`endif

// File: hw/rrw_pkg.sv
// types for the record window and syndrome block
`default_nettype none
package rrw_pkg;
   typedef enum logic [1:0] {EL_USR, EL_OS, EL_HYP, EL_MON} rrw_level_e;
   typedef enum logic [2:0] {
      WIN_NONE, WIN_CTL, WIN_FEAT, WIN_STAT, WIN_SYN_OS, WIN_SYN_HYP
   } rrw_win_e;
   typedef enum logic [2:0] {
      EXC_SYNC, EXC_SERR_PHYS, EXC_SERR_VIRT, EXC_INST_ABORT,
      EXC_ALIGN, EXC_DATA_ABORT, EXC_ILLEGAL_STATE
   } rrw_exc_e;
   typedef struct packed {
      logic rsp_valid;
      logic [63:0] rsp_rdata;
      logic rsp_undef;
      logic rsp_trap_hyp;
      logic rsp_trap_mon;
      logic core_we;
      logic clu_we;
      logic [63:0] wdata;
   } rrw_top_s;
   typedef struct packed {
      logic [31:0] syn_os;
      logic [31:0] syn_hyp;
   } rrw_bank_s;
endpackage : rrw_pkg
`default_nettype wire

// File: hw/rrw_syn_bank.sv
// storage of the two syndrome registers
`include "rrw_consts.svh"
`default_nettype none
module rrw_syn_bank (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // access side
   rrw_syn_if.bank sb
);
   rrw_pkg::rrw_bank_s st_q;
   rrw_pkg::rrw_bank_s st_d;

   always_comb
   begin
      st_d = st_q;
      // software write first, exception capture overrides
      if (sb.wr_os)
      begin
         st_d.syn_os = sb.wr_data;
      end
      if (sb.wr_hyp)
      begin
         st_d.syn_hyp = sb.wr_data;
      end
      if (sb.cap_valid && !sb.cap_hyp)
      begin
         st_d.syn_os = sb.cap_value;
      end
      if (sb.cap_valid && sb.cap_hyp)
      begin
         st_d.syn_hyp = sb.cap_value;
      end
   end

   // reset value is a convenience only
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         st_q.syn_os <= `RRW_SYN_RESET;
         st_q.syn_hyp <= `RRW_SYN_RESET;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign sb.syn_os_q = st_q.syn_os;
   assign sb.syn_hyp_q = st_q.syn_hyp;
endmodule : rrw_syn_bank
`default_nettype wire

// File: hw/rrw_syn_if.sv
// carrier between access logic and syndrome bank
`default_nettype none
interface rrw_syn_if;
   logic cap_valid;
   logic cap_hyp;
   logic [31:0] cap_value;
   logic wr_os;
   logic wr_hyp;
   logic [31:0] wr_data;
   logic [31:0] syn_os_q;
   logic [31:0] syn_hyp_q;
   modport access (
      output cap_valid, cap_hyp, cap_value, wr_os, wr_hyp, wr_data,
      input syn_os_q, syn_hyp_q
   );
   modport bank (
      input cap_valid, cap_hyp, cap_value, wr_os, wr_hyp, wr_data,
      output syn_os_q, syn_hyp_q
   );
endinterface : rrw_syn_if
`default_nettype wire

// File: hw/rrw_top.sv
// record windows, access checks and syndrome formation
`include "rrw_consts.svh"
`default_nettype none

// Function
// - select 0 sends fault-inject control accesses to the core record.
// - select 1 forwards all three windows to the cluster record instead.
// - select 0 feature and status windows return the core record registers.
// - control window is read-write at encoding 3,0,15,2,1.
// - feature window is read-only at encoding 3,0,15,2,0.
// - top level always allowed; middle levels gated by aux control bit 5.
// - any window access from the lowest level is undefined.
// - hypervisor trap bit traps non-secure OS-level accesses to hypervisor.
// - monitor trap bit traps OS and hypervisor accesses to monitor.
// - 32-bit OS-level syndrome captured on each exception to that level.
// - separate 32-bit hypervisor-level syndrome with the same layout.
// - class in 31:26, length flag in 25, syndrome in 24:0.
// - length flag is 0 for 16-bit, 1 for 32-bit trapping instruction.
// - length flag forced to 1 for listed exception kinds and class 0.
// - virtual system error copies bits 24:0 of the virtual syndrome.
// - physical system error: format flag 0, error type 000 or 001.
// - abort-type bit zero for physical system error and data abort.
// - hypervisor syndrome needs no defined reset value.
// - select bit chooses core record 0 or cluster record 1.
module rrw_top (
   // clock and reset
   input wire logic CLK,
   input wire logic NRST,
   // system register access request
   input wire logic REQ_VALID,
   input wire logic REQ_WRITE,
   input wire logic [1:0] REQ_OP0,
   input wire logic [2:0] REQ_OP1,
   input wire logic [3:0] REQ_CRN,
   input wire logic [3:0] REQ_CRM,
   input wire logic [2:0] REQ_OP2,
   input wire logic [63:0] REQ_WDATA,
   // execution context
   input wire logic [1:0] CUR_LEVEL,
   input wire logic NONSECURE,
   input wire logic HYP_TRAP_ERR,
   input wire logic MON_TRAP_ERR,
   input wire logic [63:0] HYP_AUX_CONTROL,
   input wire logic [63:0] MON_AUX_CONTROL,
   input wire logic RECORD_SELECT,
   // record registers outside the block
   input wire logic [63:0] CORE_FI_CTL_RDATA,
   input wire logic [63:0] CLU_FI_CTL_RDATA,
   input wire logic [63:0] CORE_FI_FEAT_RDATA,
   input wire logic [63:0] CLU_FI_FEAT_RDATA,
   input wire logic [63:0] CORE_STATUS_RDATA,
   input wire logic [63:0] CLU_STATUS_RDATA,
   // exception report
   input wire logic EXC_VALID,
   input wire logic EXC_TO_HYP,
   input wire logic [2:0] EXC_KIND,
   input wire logic [5:0] EXC_CLASS,
   input wire logic EXC_LEN32,
   input wire logic EXC_SYN_VALID,
   input wire logic [24:0] EXC_SYNDROME,
   input wire logic EXC_UNRECOVERABLE,
   input wire logic [24:0] VIRT_SERR_SYNDROME,
   // access response
   output logic RSP_VALID,
   output logic [63:0] RSP_RDATA,
   output logic RSP_UNDEF,
   output logic RSP_TRAP_HYP,
   output logic RSP_TRAP_MON,
   // record write strobes
   output logic CORE_FI_CTL_WE,
   output logic CLU_FI_CTL_WE,
   output logic [63:0] FI_CTL_WDATA,
   // syndrome registers
   output logic [31:0] SYN_OS_LEVEL,
   output logic [31:0] SYN_HYP_LEVEL
);
   rrw_pkg::rrw_top_s st_q;
   rrw_pkg::rrw_top_s st_d;
   rrw_syn_if syn ();

   // encoding decode
   function automatic rrw_pkg::rrw_win_e win_of(
      input logic [1:0] op0,
      input logic [2:0] op1,
      input logic [3:0] crn,
      input logic [3:0] crm,
      input logic [2:0] op2
   );
      logic [`RRW_ENC_W-1:0] enc;
      enc = {op0, op1, crn, crm, op2};
      if (enc == `RRW_ENC_FI_CTL)
      begin
         win_of = rrw_pkg::WIN_CTL;
      end
      else if (enc == `RRW_ENC_FI_FEAT)
      begin
         win_of = rrw_pkg::WIN_FEAT;
      end
      else if (enc == `RRW_ENC_REC_STAT)
      begin
         win_of = rrw_pkg::WIN_STAT;
      end
      else if (enc == `RRW_ENC_SYN_OS)
      begin
         win_of = rrw_pkg::WIN_SYN_OS;
      end
      else if (enc == `RRW_ENC_SYN_HYP)
      begin
         win_of = rrw_pkg::WIN_SYN_HYP;
      end
      else
      begin
         win_of = rrw_pkg::WIN_NONE;
      end
   endfunction : win_of

   // select between core and cluster record
   function automatic logic [63:0] pick(
      input logic sel,
      input logic [63:0] core_v,
      input logic [63:0] clu_v
   );
      pick = sel ? clu_v : core_v;
   endfunction : pick

   // syndrome value for a reported exception
   function automatic logic [31:0] syndrome_of(
      input logic [2:0] kind,
      input logic [5:0] cls,
      input logic len32,
      input logic syn_valid,
      input logic [24:0] cls_syn,
      input logic unrec,
      input logic [24:0] vsyn
   );
      logic len_flag;
      logic [24:0] s;
      len_flag = len32;
      s = cls_syn;
      if (kind == rrw_pkg::EXC_SERR_PHYS || kind == rrw_pkg::EXC_SERR_VIRT
          || kind == rrw_pkg::EXC_INST_ABORT || kind == rrw_pkg::EXC_ALIGN
          || kind == rrw_pkg::EXC_ILLEGAL_STATE
          || (kind == rrw_pkg::EXC_DATA_ABORT && !syn_valid)
          || cls == `RRW_CLASS_ZERO)
      begin
         len_flag = 1'b1;
      end
      if (kind == rrw_pkg::EXC_SERR_VIRT)
      begin
         s = vsyn;
      end
      else if (kind == rrw_pkg::EXC_SERR_PHYS)
      begin
         s[`RRW_FMT_BIT] = 1'b0;
         s[`RRW_ERRTYPE_HI:`RRW_ERRTYPE_LO] = {2'b00, unrec};
         s[`RRW_ABORT_TYPE_BIT] = 1'b0;
      end
      else if (kind == rrw_pkg::EXC_DATA_ABORT)
      begin
         s[`RRW_ABORT_TYPE_BIT] = 1'b0;
      end
      syndrome_of = {cls, len_flag, s};
   endfunction : syndrome_of

   rrw_pkg::rrw_win_e win;
   rrw_pkg::rrw_level_e lvl;
   logic reach;
   logic rec_win;
   logic undef;
   logic trap_hyp;
   logic trap_mon;
   logic ok;
   logic [63:0] rdata;

   // access permission and trap decision
   always_comb
   begin
      win = win_of(REQ_OP0, REQ_OP1, REQ_CRN, REQ_CRM, REQ_OP2);
      lvl = rrw_pkg::rrw_level_e'(CUR_LEVEL);
      rec_win = (win == rrw_pkg::WIN_CTL) || (win == rrw_pkg::WIN_FEAT)
         || (win == rrw_pkg::WIN_STAT);
      reach = 1'b0;
      trap_hyp = 1'b0;
      trap_mon = 1'b0;
      undef = 1'b0;
      if (lvl == rrw_pkg::EL_MON)
      begin
         reach = 1'b1;
      end
      else if (lvl == rrw_pkg::EL_HYP)
      begin
         reach = MON_AUX_CONTROL[`RRW_AUX_EN_BIT];
      end
      else if (lvl == rrw_pkg::EL_OS)
      begin
         reach = MON_AUX_CONTROL[`RRW_AUX_EN_BIT]
            && HYP_AUX_CONTROL[`RRW_AUX_EN_BIT];
      end
      else
      begin
         reach = 1'b0;
      end
      if (win == rrw_pkg::WIN_NONE)
      begin
         undef = 1'b1;
      end
      else if (rec_win)
      begin
         if (!reach)
         begin
            undef = 1'b1;
         end
         else if (lvl == rrw_pkg::EL_OS && NONSECURE && HYP_TRAP_ERR)
         begin
            trap_hyp = 1'b1;
         end
         else if ((lvl == rrw_pkg::EL_OS || lvl == rrw_pkg::EL_HYP)
                  && MON_TRAP_ERR)
         begin
            trap_mon = 1'b1;
         end
         else if (REQ_WRITE && win != rrw_pkg::WIN_CTL)
         begin
            undef = 1'b1;
         end
      end
      else if (win == rrw_pkg::WIN_SYN_OS)
      begin
         undef = (lvl == rrw_pkg::EL_USR);
      end
      else
      begin
         undef = (lvl == rrw_pkg::EL_USR) || (lvl == rrw_pkg::EL_OS);
      end
      ok = REQ_VALID && !undef && !trap_hyp && !trap_mon;
   end

   // read data steering, no local copy of record contents
   always_comb
   begin
      rdata = `RRW_DATA_RESET;
      if (win == rrw_pkg::WIN_CTL)
      begin
         rdata = pick(RECORD_SELECT, CORE_FI_CTL_RDATA,
            CLU_FI_CTL_RDATA);
      end
      else if (win == rrw_pkg::WIN_FEAT)
      begin
         rdata = pick(RECORD_SELECT, CORE_FI_FEAT_RDATA,
            CLU_FI_FEAT_RDATA);
      end
      else if (win == rrw_pkg::WIN_STAT)
      begin
         rdata = pick(RECORD_SELECT, CORE_STATUS_RDATA,
            CLU_STATUS_RDATA);
      end
      else if (win == rrw_pkg::WIN_SYN_OS)
      begin
         rdata = {32'h0000_0000, syn.syn_os_q};
      end
      else if (win == rrw_pkg::WIN_SYN_HYP)
      begin
         rdata = {32'h0000_0000, syn.syn_hyp_q};
      end
   end

   // next state of response and strobes
   always_comb
   begin
      st_d = st_q;
      st_d.rsp_valid = REQ_VALID;
      st_d.rsp_undef = REQ_VALID && undef;
      st_d.rsp_trap_hyp = REQ_VALID && trap_hyp;
      st_d.rsp_trap_mon = REQ_VALID && trap_mon;
      st_d.rsp_rdata = (ok && !REQ_WRITE) ? rdata : `RRW_DATA_RESET;
      st_d.core_we = ok && REQ_WRITE && win == rrw_pkg::WIN_CTL
         && !RECORD_SELECT;
      st_d.clu_we = ok && REQ_WRITE && win == rrw_pkg::WIN_CTL
         && RECORD_SELECT;
      st_d.wdata = (ok && REQ_WRITE) ? REQ_WDATA : st_q.wdata;
   end

   always_ff @(posedge CLK)
   begin
      if (!NRST)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // syndrome bank hookup
   assign syn.cap_valid = EXC_VALID;
   assign syn.cap_hyp = EXC_TO_HYP;
   assign syn.cap_value = syndrome_of(rrw_pkg::rrw_exc_e'(EXC_KIND),
      EXC_CLASS, EXC_LEN32, EXC_SYN_VALID, EXC_SYNDROME, EXC_UNRECOVERABLE,
      VIRT_SERR_SYNDROME);
   assign syn.wr_os = ok && REQ_WRITE && win == rrw_pkg::WIN_SYN_OS;
   assign syn.wr_hyp = ok && REQ_WRITE && win == rrw_pkg::WIN_SYN_HYP;
   assign syn.wr_data = REQ_WDATA[31:0];

   rrw_syn_bank u_bank (
      .clk(CLK),
      .nrst(NRST),
      .sb(syn.bank)
   );

   assign RSP_VALID = st_q.rsp_valid;
   assign RSP_RDATA = st_q.rsp_rdata;
   assign RSP_UNDEF = st_q.rsp_undef;
   assign RSP_TRAP_HYP = st_q.rsp_trap_hyp;
   assign RSP_TRAP_MON = st_q.rsp_trap_mon;
   assign CORE_FI_CTL_WE = st_q.core_we;
   assign CLU_FI_CTL_WE = st_q.clu_we;
   assign FI_CTL_WDATA = st_q.wdata;
   assign SYN_OS_LEVEL = syn.syn_os_q;
   assign SYN_HYP_LEVEL = syn.syn_hyp_q;
endmodule : rrw_top
`default_nettype wire

// File: tb/rrw_top_chk.sv
// assertions on the ports of the record window block
`default_nettype none
module rrw_top_chk (
   // clock and reset
   input wire logic CLK,
   input wire logic NRST,
   // request and context
   input wire logic REQ_VALID,
   input wire logic REQ_WRITE,
   input wire logic [1:0] REQ_OP0,
   input wire logic [2:0] REQ_OP1,
   input wire logic [3:0] REQ_CRN,
   input wire logic [3:0] REQ_CRM,
   input wire logic [2:0] REQ_OP2,
   input wire logic [1:0] CUR_LEVEL,
   input wire logic NONSECURE,
   input wire logic HYP_TRAP_ERR,
   input wire logic MON_TRAP_ERR,
   input wire logic [63:0] HYP_AUX_CONTROL,
   input wire logic [63:0] MON_AUX_CONTROL,
   input wire logic RECORD_SELECT,
   input wire logic [63:0] CORE_FI_CTL_RDATA,
   input wire logic [63:0] CLU_FI_CTL_RDATA,
   // exception report
   input wire logic EXC_VALID,
   input wire logic EXC_TO_HYP,
   input wire logic [2:0] EXC_KIND,
   input wire logic [5:0] EXC_CLASS,
   input wire logic EXC_UNRECOVERABLE,
   input wire logic [24:0] VIRT_SERR_SYNDROME,
   // responses
   input wire logic RSP_VALID,
   input wire logic [63:0] RSP_RDATA,
   input wire logic RSP_UNDEF,
   input wire logic RSP_TRAP_HYP,
   input wire logic RSP_TRAP_MON,
   input wire logic CORE_FI_CTL_WE,
   input wire logic CLU_FI_CTL_WE,
   input wire logic [31:0] SYN_OS_LEVEL,
   input wire logic [31:0] SYN_HYP_LEVEL
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] enc;
   logic ctl_req;
   logic feat_req;
   assign enc = {REQ_OP0, REQ_OP1, REQ_CRN, REQ_CRM, REQ_OP2};
   assign ctl_req = REQ_VALID && enc == {2'h3, 3'h0, 4'hF, 4'h2, 3'h1};
   assign feat_req = REQ_VALID && enc == {2'h3, 3'h0, 4'hF, 4'h2, 3'h0};
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!NRST);
   a_rsp_next: assert property (
      RSP_VALID == $past(REQ_VALID)) else $error("response timing off");
   a_user_undef: assert property (
      REQ_VALID && CUR_LEVEL == 2'h0 |=> RSP_UNDEF && RSP_RDATA == 64'h0
      && !CORE_FI_CTL_WE && !CLU_FI_CTL_WE) else $error("user access ok");
   a_ctl_read_steer: assert property (
      ctl_req && !REQ_WRITE && CUR_LEVEL == 2'h3 |=> RSP_RDATA ==
      ($past(RECORD_SELECT) ? $past(CLU_FI_CTL_RDATA) :
      $past(CORE_FI_CTL_RDATA))) else $error("control read misrouted");
   a_ctl_write_steer: assert property (
      ctl_req && REQ_WRITE && CUR_LEVEL == 2'h3 |=> {CORE_FI_CTL_WE,
      CLU_FI_CTL_WE} == {!$past(RECORD_SELECT), $past(RECORD_SELECT)})
      else $error("control write misrouted");
   a_feat_no_write: assert property (
      feat_req && REQ_WRITE |=> !CORE_FI_CTL_WE && !CLU_FI_CTL_WE)
      else $error("feature window written");
   a_hyp_trap: assert property (
      ctl_req && CUR_LEVEL == 2'h1 && NONSECURE && HYP_TRAP_ERR &&
      HYP_AUX_CONTROL[5] && MON_AUX_CONTROL[5] |=> RSP_TRAP_HYP &&
      !RSP_TRAP_MON && !RSP_UNDEF) else $error("hypervisor trap missing");
   a_mon_trap: assert property (
      ctl_req && CUR_LEVEL == 2'h2 && MON_TRAP_ERR && MON_AUX_CONTROL[5]
      |=> RSP_TRAP_MON && !RSP_TRAP_HYP) else $error("monitor trap missing");
   a_syn_class: assert property (
      EXC_VALID && !EXC_TO_HYP |=> SYN_OS_LEVEL[31:26] == $past(EXC_CLASS))
      else $error("class not captured");
   a_serr_fields: assert property (
      EXC_VALID && EXC_TO_HYP && EXC_KIND == 3'h1 |=> SYN_HYP_LEVEL[25:24]
      == 2'b10 && SYN_HYP_LEVEL[12:9] == {2'b00, $past(EXC_UNRECOVERABLE),
      1'b0}) else $error("system error fields wrong");
   a_virt_copy: assert property (
      EXC_VALID && !EXC_TO_HYP && EXC_KIND == 3'h2 |=> SYN_OS_LEVEL[24:0]
      == $past(VIRT_SERR_SYNDROME)) else $error("virtual syndrome lost");
endmodule : rrw_top_chk
`default_nettype wire

// File: tb/rrw_top_tb.sv
// self-checking bench for the record window and syndrome block
`default_nettype none
module rrw_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] e_ctl = {2'h3, 3'h0, 4'hF, 4'h2, 3'h1};
   localparam logic [15:0] e_feat = {2'h3, 3'h0, 4'hF, 4'h2, 3'h0};
   localparam logic [15:0] e_stat = {2'h3, 3'h0, 4'h5, 4'h4, 3'h2};
   localparam logic [15:0] e_sos = {2'h3, 3'h0, 4'h5, 4'h2, 3'h0};
   localparam logic [15:0] e_shyp = {2'h3, 3'h4, 4'h5, 4'h2, 3'h0};
   localparam logic [15:0] win [3] = '{e_ctl, e_feat, e_stat};
   localparam logic [63:0] wd = 64'h5A5A_0000_1234_00C3;
   logic CLK, NRST, REQ_VALID, REQ_WRITE, NONSECURE, HYP_TRAP_ERR;
   logic MON_TRAP_ERR, RECORD_SELECT, EXC_VALID, EXC_TO_HYP, EXC_LEN32;
   logic EXC_SYN_VALID, EXC_UNRECOVERABLE, RSP_VALID, RSP_UNDEF, RSP_TRAP_HYP;
   logic RSP_TRAP_MON, CORE_FI_CTL_WE, CLU_FI_CTL_WE;
   logic [1:0] REQ_OP0, CUR_LEVEL;
   logic [2:0] REQ_OP1, REQ_OP2, EXC_KIND;
   logic [3:0] REQ_CRN, REQ_CRM;
   logic [5:0] EXC_CLASS;
   logic [24:0] EXC_SYNDROME, VIRT_SERR_SYNDROME;
   logic [31:0] SYN_OS_LEVEL, SYN_HYP_LEVEL;
   logic [63:0] REQ_WDATA, HYP_AUX_CONTROL, MON_AUX_CONTROL, RSP_RDATA;
   logic [63:0] CORE_FI_CTL_RDATA, CLU_FI_CTL_RDATA, CORE_FI_FEAT_RDATA;
   logic [63:0] CLU_FI_FEAT_RDATA, CORE_STATUS_RDATA, CLU_STATUS_RDATA;
   logic [63:0] FI_CTL_WDATA;
   logic [63:0] rec [6];
   int failures;
   int check_count;
   assign CORE_FI_CTL_RDATA = rec[0];
   assign CORE_FI_FEAT_RDATA = rec[1];
   assign CORE_STATUS_RDATA = rec[2];
   assign CLU_FI_CTL_RDATA = rec[3];
   assign CLU_FI_FEAT_RDATA = rec[4];
   assign CLU_STATUS_RDATA = rec[5];
   rrw_top i_dut (.*);
   task automatic check(input logic [63:0] got, input logic [63:0] ex);
      check_count++;
      if (got !== ex)
      begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, ex);
      end
   endtask : check
   task automatic wrap_up();
      if (failures == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : wrap_up
   // request stays up so accesses run back to back
   task automatic acc(input logic [1:0] lvl, input logic wr,
      input logic [15:0] enc, input logic [63:0] ex, input logic [2:0] fl,
      input logic [1:0] we);
      CUR_LEVEL = lvl;
      REQ_WRITE = wr;
      {REQ_OP0, REQ_OP1, REQ_CRN, REQ_CRM, REQ_OP2} = enc;
      REQ_VALID = 1'b1;
      @(negedge CLK);
      check({60'h0, RSP_VALID, RSP_UNDEF, RSP_TRAP_HYP, RSP_TRAP_MON},
         {60'h0, 1'b1, fl});
      check(RSP_RDATA, ex);
      check({62'h0, CORE_FI_CTL_WE, CLU_FI_CTL_WE}, {62'h0, we});
   endtask : acc
   task automatic exc(input logic hyp, input logic [2:0] kind,
      input logic [5:0] cls, input logic len, input logic vld,
      input logic un);
      {EXC_TO_HYP, EXC_KIND, EXC_CLASS} = {hyp, kind, cls};
      {EXC_LEN32, EXC_SYN_VALID, EXC_UNRECOVERABLE} = {len, vld, un};
      EXC_SYNDROME = {cls, 19'h20A55};
      VIRT_SERR_SYNDROME = ~{cls, 19'h20A55};
      EXC_VALID = 1'b1;
      @(negedge CLK);
   endtask : exc
   task automatic sck(input logic hyp, input logic [31:0] m,
      input logic [31:0] e);
      check({32'h0, (hyp ? SYN_HYP_LEVEL : SYN_OS_LEVEL) & m}, {32'h0, e});
   endtask : sck
   task automatic idle();
      REQ_VALID = 1'b0;
      EXC_VALID = 1'b0;
      @(negedge CLK);
   endtask : idle
   initial
   begin
      CLK = 1'b0;
      forever #12.5 CLK = ~CLK;
   end
   initial
   begin
      {NRST, REQ_VALID, REQ_WRITE, NONSECURE, HYP_TRAP_ERR} = 5'h01;
      {MON_TRAP_ERR, RECORD_SELECT, EXC_VALID, EXC_TO_HYP} = 4'h0;
      {EXC_LEN32, EXC_SYN_VALID, EXC_UNRECOVERABLE} = 3'h0;
      {EXC_KIND, EXC_CLASS} = 9'h0;
      {REQ_OP0, REQ_OP1, REQ_CRN, REQ_CRM, REQ_OP2, CUR_LEVEL} = 18'h0;
      {EXC_SYNDROME, VIRT_SERR_SYNDROME} = 50'h0;
      {HYP_AUX_CONTROL, MON_AUX_CONTROL} = {64'h20, 64'h20};
      REQ_WDATA = wd;
      foreach (rec[i]) rec[i] = 64'h0;
      repeat (4) @(negedge CLK);
      NRST = 1'b1;
      @(negedge CLK);
      for (int p = 0; p < 256; p += 165)
      begin
         foreach (rec[i]) rec[i] = {8'(p), 48'h0, 8'(i + 1)};
         for (int i = 0; i < 6; i++)
         begin
            RECORD_SELECT = (i > 2);
            acc(2'h3, 1'b0, win[i % 3], rec[i], 3'h0, 2'h0);
         end
      end
      for (int s = 0; s < 2; s++)
      begin
         RECORD_SELECT = s[0];
         REQ_WDATA = wd + 64'(s);
         acc(2'h3, 1'b1, e_ctl, 64'h0, 3'h0, s ? 2'h1 : 2'h2);
         check(FI_CTL_WDATA, wd + 64'(s));
      end
      acc(2'h3, 1'b1, e_feat, 64'h0, 3'h4, 2'h0);
      acc(2'h3, 1'b1, e_stat, 64'h0, 3'h4, 2'h0);
      acc(2'h3, 1'b0, e_ctl ^ 16'h6, 64'h0, 3'h4, 2'h0);
      acc(2'h0, 1'b0, e_ctl, 64'h0, 3'h4, 2'h0);
      acc(2'h0, 1'b0, e_sos, 64'h0, 3'h4, 2'h0);
      RECORD_SELECT = 1'b0;
      acc(2'h1, 1'b0, e_ctl, rec[0], 3'h0, 2'h0);
      MON_AUX_CONTROL = 64'h0;
      acc(2'h2, 1'b0, e_feat, 64'h0, 3'h4, 2'h0);
      acc(2'h1, 1'b0, e_ctl, 64'h0, 3'h4, 2'h0);
      acc(2'h3, 1'b0, e_ctl, rec[0], 3'h0, 2'h0);
      {MON_AUX_CONTROL, HYP_AUX_CONTROL} = {64'h20, 64'h0};
      acc(2'h1, 1'b0, e_ctl, 64'h0, 3'h4, 2'h0);
      acc(2'h2, 1'b0, e_ctl, rec[0], 3'h0, 2'h0);
      {HYP_AUX_CONTROL, NONSECURE} = {64'h20, 1'b1};
      {HYP_TRAP_ERR, MON_TRAP_ERR} = 2'h3;
      acc(2'h1, 1'b1, e_ctl, 64'h0, 3'h2, 2'h0);
      NONSECURE = 1'b0;
      acc(2'h1, 1'b0, e_ctl, 64'h0, 3'h1, 2'h0);
      acc(2'h2, 1'b0, e_ctl, 64'h0, 3'h1, 2'h0);
      acc(2'h3, 1'b0, e_ctl, rec[0], 3'h0, 2'h0);
      {NONSECURE, HYP_TRAP_ERR, MON_TRAP_ERR} = 3'h4;
      REQ_WDATA = wd;
      acc(2'h3, 1'b1, e_sos, 64'h0, 3'h0, 2'h0);
      acc(2'h3, 1'b0, e_sos, {32'h0, wd[31:0]}, 3'h0, 2'h0);
      acc(2'h3, 1'b1, e_shyp, 64'h0, 3'h0, 2'h0);
      acc(2'h2, 1'b0, e_shyp, {32'h0, wd[31:0]}, 3'h0, 2'h0);
      acc(2'h1, 1'b0, e_shyp, 64'h0, 3'h4, 2'h0);
      idle();
      exc(1'b0, 3'h0, 6'h15, 1'b0, 1'b1, 1'b0);
      sck(1'b0, 32'hFFFF_FFFF, {6'h15, 1'b0, 6'h15, 19'h20A55});
      exc(1'b0, 3'h0, 6'h16, 1'b1, 1'b1, 1'b0);
      sck(1'b0, 32'hFE00_0000, {6'h16, 1'b1, 25'h0});
      exc(1'b0, 3'h0, 6'h00, 1'b0, 1'b1, 1'b0);
      sck(1'b0, 32'hFE00_0000, {6'h00, 1'b1, 25'h0});
      for (int k = 3; k < 7; k++)
      begin
         exc(1'b1, 3'(k), 6'(k + 32), 1'b0, 1'b0, 1'b0);
         sck(1'b1, 32'hFE00_0000, {6'(k + 32), 1'b1, 25'h0});
      end
      exc(1'b1, 3'h5, 6'h24, 1'b0, 1'b1, 1'b0);
      sck(1'b1, 32'hFE00_0200, {6'h24, 1'b0, 25'h0});
      for (int u = 0; u < 2; u++)
      begin
         exc(1'b1, 3'h1, 6'h2F, 1'b0, 1'b1, u[0]);
         sck(1'b1, 32'hFF00_1E00, {6'h2F, 15'h4000, u[0], 10'h0});
      end
      exc(1'b0, 3'h2, 6'h2F, 1'b0, 1'b1, 1'b0);
      sck(1'b0, 32'hFFFF_FFFF, {6'h2F, 1'b1, ~{6'h2F, 19'h20A55}});
      idle();
      wrap_up();
   end
endmodule : rrw_top_tb
bind rrw_top rrw_top_chk i_chk (.*);
`default_nettype wire
